/* hw/sanr_pkg.sv */
// Package with offsets, bit positions, reset values and frame constants of the register group
package sanr_pkg;

	// ------------------------------------------------------------
	// Register addresses on the management bus
	// ------------------------------------------------------------
	localparam logic [4:0] ADDR_AUTONEG_EXPANSION         = 5'h06;
	localparam logic [4:0] ADDR_NEXT_PAGE_TRANSMIT        = 5'h07;
	localparam logic [4:0] ADDR_NEXT_PAGE_RECEIVE         = 5'h08;
	localparam logic [4:0] ADDR_EXTENDED_STATUS           = 5'h0f;
	localparam logic [4:0] ADDR_AUTONEG_INTERRUPT_CONTROL = 5'h10;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int EXP_NP_ABLE_BIT   = 2;
	localparam int EXP_PAGE_RCVD_BIT = 1;
	localparam int NP_NEXT_BIT       = 15;
	localparam int NP_ACK_BIT        = 14;
	localparam int NP_MSG_BIT        = 13;
	localparam int NP_ACK2_BIT       = 12;
	localparam int NP_TOGGLE_BIT     = 11;
	localparam int NP_CODE_MSB       = 10;
	localparam int NP_CODE_W         = 11;
	localparam int IRQ_STATUS_BIT    = 1;
	localparam int IRQ_ENABLE_BIT    = 0;

	// ------------------------------------------------------------
	// Values after reset and fixed read values
	// ------------------------------------------------------------
	localparam logic                 RST_NP_NEXT      = 1'b0;
	localparam logic                 RST_NP_MSG       = 1'b1;
	localparam logic                 RST_NP_ACK2      = 1'b0;
	localparam logic                 RST_NP_TOGGLE    = 1'b0;
	localparam logic [NP_CODE_W-1:0] RST_NP_CODE      = 11'h001;
	localparam logic [15:0]          RST_NP_RECEIVE   = 16'h0000;
	localparam logic                 RST_PAGE_RCVD    = 1'b0;
	localparam logic                 RST_IRQ_ENABLE   = 1'b1;
	localparam logic                 RST_IRQ_STATUS   = 1'b0;
	localparam logic [15:0]          EXT_STATUS_VALUE = 16'h8000;
	localparam logic [15:0]          READ_ZERO        = 16'h0000;

	// ------------------------------------------------------------
	// Management frame layout
	// ------------------------------------------------------------
	localparam logic [1:0] MDIO_OP_WRITE = 2'b01;
	localparam logic [1:0] MDIO_OP_READ  = 2'b10;
	localparam logic [4:0] CNT_OP_LAST   = 5'h01;
	localparam logic [4:0] CNT_ADDR_LAST = 5'h09;
	localparam logic [4:0] CNT_DATA_LAST = 5'h0f;
	localparam logic [4:0] CNT_ZERO      = 5'h00;
	localparam logic [4:0] DEF_PHY_ADDR  = 5'h01;

	// ------------------------------------------------------------
	// Frame decoder states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SANR_IDLE,
		SANR_START,
		SANR_OP,
		SANR_ADDR,
		SANR_TA,
		SANR_DATA
	} sanr_state_t;

endpackage

/* hw/sanr_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module sanr_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// ------------------------------------------------------------
	// One pair of flops per bit
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge mclk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					meta_ff[i] <= 1'b0;
					sync_ff[i] <= 1'b0;
				end
				else
				begin
					meta_ff[i] <= async_in[i];
					sync_ff[i] <= meta_ff[i];
				end
			end
		end
	endgenerate

	assign sync_out = sync_ff;

endmodule

/* hw/sanr_regs.sv */
// Management register group for auto-negotiation next page exchange and interrupt
`timescale 1ns/1ps

// What this block does
// - Expansion bit 2 always reads one
// - Page received bit sets, clears on read
// - Transmit next page flag writable, reset zero
// - Transmit code writable, message page selects, null
// - Transmit acknowledge 2 writable, reset zero
// - Transmit toggle read-only, inverts per page sent
// - Receive register read-only, resets to zero
// - Receive register loads the whole received word on page reception
// - Extended status bit 15 reads one
// - Extended status bits 14 to 12 read zero
// - Enabled interrupt sets on negotiation complete
// - Interrupt status stays until written zero
// - Disabled interrupt forces status to zero
// - Interrupt pin follows interrupt status bit
// - Interrupt enable writable, reset one
module sanr_regs #(
	parameter logic [4:0] PHY_ADDR = sanr_pkg::DEF_PHY_ADDR
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        mdc,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe,
	input  wire logic        page_rx_strobe,
	input  wire logic [15:0] page_rx_word,
	input  wire logic        np_tx_sent,
	input  wire logic        an_cycle_done,
	output logic      [15:0] np_tx_page,
	output logic             negotiation_done_irq_out
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic                           mdc_s;
	logic                           mdio_s;
	logic                           mdc_prev_ff;
	logic                           mdc_rise;
	sanr_pkg::sanr_state_t          state_ff;
	logic [4:0]                     cnt_ff;
	logic [1:0]                     op_ff;
	logic [9:0]                     addr_ff;
	logic [4:0]                     reg_ff;
	logic                           pre_ff;
	logic                           rd_hit_ff;
	logic                           wr_hit_ff;
	logic [15:0]                    sh_in_ff;
	logic [15:0]                    sh_out_ff;
	logic                           mdio_out_ff;
	logic                           mdio_oe_ff;
	logic [9:0]                     addr_full;
	logic [4:0]                     cur_reg;
	logic                           phy_match;
	logic                           addr_done;
	logic                           rd_clear_fire;
	logic                           wr_fire;
	logic [15:0]                    wr_data;
	logic [15:0]                    rd_data;
	logic                           page_rcvd_ff;
	logic                           np_next_ff;
	logic                           np_msg_ff;
	logic                           np_ack2_ff;
	logic                           np_toggle_ff;
	logic [sanr_pkg::NP_CODE_W-1:0] np_code_ff;
	logic [15:0]                    np_rx_ff;
	logic                           irq_en_ff;
	logic                           irq_stat_ff;
	logic                           nxt_irq_en;
	logic                           nxt_irq_stat;
	logic                           wr_np_tx;
	logic                           wr_irq;

	// ------------------------------------------------------------
	// Pin synchronisation and clock edge detection
	// ------------------------------------------------------------
	sanr_sync #(
		.WIDTH (2)
	) u_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.async_in ({mdc, mdio_in}),
		.sync_out ({mdc_s, mdio_s})
	);

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			mdc_prev_ff <= 1'b0;
		else
			mdc_prev_ff <= mdc_s;
	end

	assign mdc_rise = mdc_s & ~mdc_prev_ff;

	// ------------------------------------------------------------
	// Frame decode helpers
	// ------------------------------------------------------------
	assign addr_full     = {addr_ff[8:0], mdio_s};
	assign cur_reg       = addr_full[4:0];
	assign phy_match     = (addr_full[9:5] == PHY_ADDR);
	assign addr_done     = mdc_rise && (state_ff == sanr_pkg::SANR_ADDR) && (cnt_ff == sanr_pkg::CNT_ADDR_LAST);
	assign rd_clear_fire = addr_done && phy_match && (op_ff == sanr_pkg::MDIO_OP_READ)
	                       && (cur_reg == sanr_pkg::ADDR_AUTONEG_EXPANSION);
	assign wr_fire       = mdc_rise && wr_hit_ff && (state_ff == sanr_pkg::SANR_DATA)
	                       && (cnt_ff == sanr_pkg::CNT_DATA_LAST);
	assign wr_data       = {sh_in_ff[14:0], mdio_s};
	assign wr_np_tx      = wr_fire && (reg_ff == sanr_pkg::ADDR_NEXT_PAGE_TRANSMIT);
	assign wr_irq        = wr_fire && (reg_ff == sanr_pkg::ADDR_AUTONEG_INTERRUPT_CONTROL);

	// ------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------
	always_comb
	begin
		case (cur_reg)
			sanr_pkg::ADDR_AUTONEG_EXPANSION:
				rd_data = {13'h0000, 1'b1, page_rcvd_ff, 1'b0};
			sanr_pkg::ADDR_NEXT_PAGE_TRANSMIT:
				rd_data = np_tx_page;
			sanr_pkg::ADDR_NEXT_PAGE_RECEIVE:
				rd_data = np_rx_ff;
			sanr_pkg::ADDR_EXTENDED_STATUS:
				rd_data = sanr_pkg::EXT_STATUS_VALUE;
			sanr_pkg::ADDR_AUTONEG_INTERRUPT_CONTROL:
				rd_data = {14'h0000, irq_stat_ff, irq_en_ff};
			default:
				rd_data = sanr_pkg::READ_ZERO;
		endcase
	end

	// ------------------------------------------------------------
	// Management frame state machine
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff    <= sanr_pkg::SANR_IDLE;
			cnt_ff      <= sanr_pkg::CNT_ZERO;
			op_ff       <= 2'h0;
			addr_ff     <= 10'h000;
			reg_ff      <= 5'h00;
			pre_ff      <= 1'b0;
			rd_hit_ff   <= 1'b0;
			wr_hit_ff   <= 1'b0;
			sh_in_ff    <= 16'h0000;
			sh_out_ff   <= 16'h0000;
			mdio_out_ff <= 1'b0;
			mdio_oe_ff  <= 1'b0;
		end
		else if (mdc_rise)
		begin
			case (state_ff)
				sanr_pkg::SANR_IDLE:
				begin
					if (mdio_s)
						pre_ff <= 1'b1;
					else if (pre_ff)
					begin
						pre_ff   <= 1'b0;
						state_ff <= sanr_pkg::SANR_START;
					end
				end
				sanr_pkg::SANR_START:
				begin
					cnt_ff   <= sanr_pkg::CNT_ZERO;
					pre_ff   <= mdio_s;
					state_ff <= mdio_s ? sanr_pkg::SANR_OP : sanr_pkg::SANR_IDLE;
				end
				sanr_pkg::SANR_OP:
				begin
					op_ff <= {op_ff[0], mdio_s};
					if (cnt_ff == sanr_pkg::CNT_OP_LAST)
					begin
						cnt_ff   <= sanr_pkg::CNT_ZERO;
						state_ff <= sanr_pkg::SANR_ADDR;
					end
					else
						cnt_ff <= cnt_ff + 5'h01;
				end
				sanr_pkg::SANR_ADDR:
				begin
					addr_ff <= addr_full;
					if (cnt_ff == sanr_pkg::CNT_ADDR_LAST)
					begin
						cnt_ff    <= sanr_pkg::CNT_ZERO;
						state_ff  <= sanr_pkg::SANR_TA;
						reg_ff    <= cur_reg;
						rd_hit_ff <= phy_match && (op_ff == sanr_pkg::MDIO_OP_READ);
						wr_hit_ff <= phy_match && (op_ff == sanr_pkg::MDIO_OP_WRITE);
						sh_out_ff <= rd_data;
					end
					else
						cnt_ff <= cnt_ff + 5'h01;
				end
				sanr_pkg::SANR_TA:
				begin
					if (cnt_ff == sanr_pkg::CNT_ZERO)
					begin
						cnt_ff <= 5'h01;
						if (rd_hit_ff)
						begin
							mdio_oe_ff  <= 1'b1;
							mdio_out_ff <= 1'b0;
						end
					end
					else
					begin
						cnt_ff   <= sanr_pkg::CNT_ZERO;
						state_ff <= sanr_pkg::SANR_DATA;
						if (rd_hit_ff)
						begin
							mdio_out_ff <= sh_out_ff[15];
							sh_out_ff   <= {sh_out_ff[14:0], 1'b0};
						end
					end
				end
				sanr_pkg::SANR_DATA:
				begin
					sh_in_ff <= wr_data;
					if (rd_hit_ff)
					begin
						mdio_out_ff <= sh_out_ff[15];
						sh_out_ff   <= {sh_out_ff[14:0], 1'b0};
					end
					if (cnt_ff == sanr_pkg::CNT_DATA_LAST)
					begin
						cnt_ff      <= sanr_pkg::CNT_ZERO;
						state_ff    <= sanr_pkg::SANR_IDLE;
						pre_ff      <= 1'b0;
						rd_hit_ff   <= 1'b0;
						wr_hit_ff   <= 1'b0;
						mdio_oe_ff  <= 1'b0;
						mdio_out_ff <= 1'b0;
					end
					else
						cnt_ff <= cnt_ff + 5'h01;
				end
				default:
				begin
					state_ff   <= sanr_pkg::SANR_IDLE;
					mdio_oe_ff <= 1'b0;
				end
			endcase
		end
	end

	assign mdio_out = mdio_out_ff;
	assign mdio_oe  = mdio_oe_ff;

	// ------------------------------------------------------------
	// Page received flag, arrival wins over read clear
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			page_rcvd_ff <= sanr_pkg::RST_PAGE_RCVD;
		else if (page_rx_strobe)
			page_rcvd_ff <= 1'b1;
		else if (rd_clear_fire)
			page_rcvd_ff <= 1'b0;
	end

	// ------------------------------------------------------------
	// Next page transmit register
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			np_next_ff <= sanr_pkg::RST_NP_NEXT;
			np_msg_ff  <= sanr_pkg::RST_NP_MSG;
			np_ack2_ff <= sanr_pkg::RST_NP_ACK2;
			np_code_ff <= sanr_pkg::RST_NP_CODE;
		end
		else if (wr_np_tx)
		begin
			np_next_ff <= wr_data[sanr_pkg::NP_NEXT_BIT];
			np_msg_ff  <= wr_data[sanr_pkg::NP_MSG_BIT];
			np_ack2_ff <= wr_data[sanr_pkg::NP_ACK2_BIT];
			np_code_ff <= wr_data[sanr_pkg::NP_CODE_MSB:0];
		end
	end

	// Toggle flips once per next page handed out on the link
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			np_toggle_ff <= sanr_pkg::RST_NP_TOGGLE;
		else if (np_tx_sent)
			np_toggle_ff <= ~np_toggle_ff;
	end

	assign np_tx_page = {np_next_ff, 1'b0, np_msg_ff, np_ack2_ff, np_toggle_ff, np_code_ff};

	// ------------------------------------------------------------
	// Next page receive register, loaded only by the negotiation engine
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			np_rx_ff <= sanr_pkg::RST_NP_RECEIVE;
		else if (page_rx_strobe)
			np_rx_ff <= page_rx_word;
	end

	// ------------------------------------------------------------
	// Interrupt control
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_irq_en   = wr_irq ? wr_data[sanr_pkg::IRQ_ENABLE_BIT] : irq_en_ff;
		nxt_irq_stat = irq_stat_ff;
		if (!nxt_irq_en)
			nxt_irq_stat = 1'b0;
		else if (an_cycle_done)
			nxt_irq_stat = 1'b1;
		else if (wr_irq && !wr_data[sanr_pkg::IRQ_STATUS_BIT])
			nxt_irq_stat = 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_en_ff   <= sanr_pkg::RST_IRQ_ENABLE;
			irq_stat_ff <= sanr_pkg::RST_IRQ_STATUS;
		end
		else
		begin
			irq_en_ff   <= nxt_irq_en;
			irq_stat_ff <= nxt_irq_stat;
		end
	end

	assign negotiation_done_irq_out = irq_stat_ff;

endmodule

/* dv/sanr_regs_assertions.sv */
// Concurrent checks on the ports of the register group
`timescale 1ns/1ps

module sanr_regs_chk (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        mdc,
	input wire logic        mdio_in,
	input wire logic        mdio_out,
	input wire logic        mdio_oe,
	input wire logic        page_rx_strobe,
	input wire logic [15:0] page_rx_word,
	input wire logic        np_tx_sent,
	input wire logic        an_cycle_done,
	input wire logic [15:0] np_tx_page,
	input wire logic        negotiation_done_irq_out
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// Interrupt flag
	// ------------------------------------------------------------
	property p_irq_rise; $rose(negotiation_done_irq_out) |-> $past(an_cycle_done); endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose without done event");
	property p_irq_fall; $fell(negotiation_done_irq_out) |-> $past(mdc, 3) && !$past(mdc, 5); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell outside a write commit");

	// ------------------------------------------------------------
	// Transmit page image
	// ------------------------------------------------------------
	property p_tog_flip; $past(np_tx_sent) |-> np_tx_page[11] != $past(np_tx_page[11]); endproperty
	a_tog_flip: assert property (p_tog_flip) else $error("toggle did not invert");
	property p_tog_hold; $changed(np_tx_page[11]) |-> $past(np_tx_sent); endproperty
	a_tog_hold: assert property (p_tog_hold) else $error("toggle moved without page sent");
	property p_np_rsvd; np_tx_page[14] == 1'b0; endproperty
	a_np_rsvd: assert property (p_np_rsvd) else $error("reserved transmit bit set");
	property p_np_wr; $changed({np_tx_page[15:12], np_tx_page[10:0]}) |-> $past(mdc, 3) && !$past(mdc, 5); endproperty
	a_np_wr: assert property (p_np_wr) else $error("transmit fields moved outside a commit");

	// ------------------------------------------------------------
	// Read answer timing
	// ------------------------------------------------------------
	property p_oe_time; $changed(mdio_oe) |-> $past(mdc, 3) && !$past(mdc, 5); endproperty
	a_oe_time: assert property (p_oe_time) else $error("drive enable off its clock slot");
	property p_ta_zero; $rose(mdio_oe) |-> !mdio_out; endproperty
	a_ta_zero: assert property (p_ta_zero) else $error("turnaround bit not zero");

	c_irq: cover property ($rose(negotiation_done_irq_out));
	c_read: cover property ($rose(mdio_oe));
	c_page: cover property (page_rx_strobe);
endmodule

bind sanr_regs sanr_regs_chk chk_u (
	.mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in),
	.mdio_out(mdio_out), .mdio_oe(mdio_oe), .page_rx_strobe(page_rx_strobe),
	.page_rx_word(page_rx_word), .np_tx_sent(np_tx_sent), .an_cycle_done(an_cycle_done),
	.np_tx_page(np_tx_page), .negotiation_done_irq_out(negotiation_done_irq_out)
);

/* dv/sanr_station.sv */
// Management station model running MDIO frames on mdc and mdio
`timescale 1ns/1ps

module sanr_station #(
	parameter logic [4:0] PHY = 5'h01
) (
	input  wire logic mclk,
	input  wire logic mdio_line,
	output logic      mdc,
	output logic      mdio_drv,
	output logic      mdio_drv_oe
);
	// Station address put into each frame; the bench may aim it elsewhere
	logic [4:0] phy_sel;

	initial
	begin
		mdc = 1'b0;
		mdio_drv = 1'b1;
		mdio_drv_oe = 1'b0;
		phy_sel = PHY;
	end

	task automatic half_bit();
		repeat (10) @(posedge mclk);
		#1;
	endtask

	// Two preamble ones then the frame; mdc stands low between frames
	task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] fr;
		fr = {2'b01, op, phy_sel, ra, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 0; i < 34; i++)
		begin
			mdio_drv_oe = !(op == sanr_pkg::MDIO_OP_READ && i >= 16);
			mdio_drv = (i < 2) ? 1'b1 : fr[33 - i];
			half_bit();
			mdc = 1'b1;
			if (i >= 18)
				rd[33 - i] = mdio_line;
			half_bit();
			mdc = 1'b0;
		end
		mdio_drv_oe = 1'b0;
		half_bit();
	endtask
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the next page register group
`timescale 1ns/1ps

module tb_top;
	logic        mclk;
	logic        rst_n;
	logic        mdc;
	logic        mdio_line;
	logic        mdio_out;
	logic        mdio_oe;
	logic        st_d;
	logic        st_oe;
	logic        page_rx_strobe;
	logic [15:0] page_rx_word;
	logic        np_tx_sent;
	logic        an_cycle_done;
	logic [15:0] np_tx_page;
	logic        irq;
	int          n_errors;
	int          checks_done;

	// Pull-up on the shared data line
	assign mdio_line = mdio_oe ? mdio_out : (st_oe ? st_d : 1'b1);

	sanr_regs dut_u (
		.mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_line),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .page_rx_strobe(page_rx_strobe),
		.page_rx_word(page_rx_word), .np_tx_sent(np_tx_sent), .an_cycle_done(an_cycle_done),
		.np_tx_page(np_tx_page), .negotiation_done_irq_out(irq)
	);

	sanr_station st_u (
		.mclk(mclk), .mdio_line(mdio_line), .mdc(mdc), .mdio_drv(st_d), .mdio_drv_oe(st_oe)
	);

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] r;
		st_u.xfer(sanr_pkg::MDIO_OP_WRITE, a, d, r);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] r;
		st_u.xfer(sanr_pkg::MDIO_OP_READ, a, 16'h0000, r);
		check(r, exp);
	endtask

	task automatic pulse(input int k);
		@(posedge mclk);
		#1;
		case (k)
			0: page_rx_strobe = 1'b1;
			1: np_tx_sent = 1'b1;
			default: an_cycle_done = 1'b1;
		endcase
		@(posedge mclk);
		#1;
		page_rx_strobe = 1'b0;
		np_tx_sent = 1'b0;
		an_cycle_done = 1'b0;
	endtask

	task automatic give_verdict();
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge mclk);
		n_errors++;
		give_verdict();
	end

	initial
	begin
		rst_n = 1'b0;
		page_rx_strobe = 1'b0;
		page_rx_word = 16'h0000;
		np_tx_sent = 1'b0;
		an_cycle_done = 1'b0;
		n_errors = 0;
		checks_done = 0;
		repeat (2) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		check(np_tx_page, 16'h2001);
		check({15'h0000, irq}, 16'h0000);
		rdc(5'h06, 16'h0004);
		rdc(5'h07, 16'h2001);
		rdc(5'h08, 16'h0000);
		rdc(5'h0f, 16'h8000);
		rdc(5'h10, 16'h0001);
		rdc(5'h05, 16'h0000);
		st_u.phy_sel = 5'h02;
		wr(5'h07, 16'h0000);
		rdc(5'h07, 16'hffff);
		st_u.phy_sel = 5'h01;
		rdc(5'h07, 16'h2001);
		wr(5'h06, 16'hffff);
		wr(5'h0f, 16'hffff);
		rdc(5'h06, 16'h0004);
		rdc(5'h0f, 16'h8000);
		page_rx_word = 16'hdfff;
		pulse(0);
		rdc(5'h06, 16'h0006);
		rdc(5'h06, 16'h0004);
		rdc(5'h08, 16'hdfff);
		wr(5'h08, 16'h0000);
		rdc(5'h08, 16'hdfff);
		wr(5'h07, 16'hffff);
		rdc(5'h07, 16'hb7ff);
		check(np_tx_page, 16'hb7ff);
		pulse(1);
		rdc(5'h07, 16'hbfff);
		pulse(1);
		check(np_tx_page, 16'hb7ff);
		wr(5'h07, 16'h0000);
		rdc(5'h07, 16'h0000);
		pulse(2);
		check({15'h0000, irq}, 16'h0001);
		rdc(5'h10, 16'h0003);
		wr(5'h10, 16'h0003);
		rdc(5'h10, 16'h0003);
		wr(5'h10, 16'h0001);
		check({15'h0000, irq}, 16'h0000);
		wr(5'h10, 16'h0000);
		pulse(2);
		check({15'h0000, irq}, 16'h0000);
		rdc(5'h10, 16'h0000);
		wr(5'h10, 16'h0001);
		pulse(2);
		wr(5'h10, 16'hfffc);
		rdc(5'h10, 16'h0000);
		wr(5'h10, 16'h0003);
		rst_n = 1'b0;
		@(posedge mclk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		rdc(5'h08, 16'h0000);
		rdc(5'h10, 16'h0001);
		give_verdict();
	end
endmodule
